// ==== logic/pwm_timer_clock_prescale.v ====
// 12-bit pwm/capture timer core with its clock and prescale configuration
// assumes oscillator and pll rates arrive as one-cycle enables on clk_i and that
// mode, period and compare values come from a control block outside this one
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module pwm_timer_clock_prescale #(
    parameter CW = 12
) (
    input  wire          clk_i,
    input  wire          rst_n_i,
    input  wire [7:0]    addr_i,
    input  wire [7:0]    wdata_i,
    input  wire          write_i,
    input  wire          read_i,
    output reg  [7:0]    rdata_o,
    input  wire          osc_tick_i,
    input  wire          pll_tick_i,
    input  wire          pwm_mode_i,
    input  wire          capture_mode_i,
    input  wire          capture_rising_i,
    input  wire          overflow_irq_en_i,
    input  wire          capture_irq_en_i,
    input  wire [CW-1:0] period_i,
    input  wire [CW-1:0] compare_a_i,
    input  wire [CW-1:0] compare_b_i,
    input  wire          half_bridge_out_b_or_capture_in_i,
    output reg           half_bridge_out_b_or_capture_in_o,
    output wire          half_bridge_out_b_or_capture_in_oe_o,
    output reg           half_bridge_out_a_o,
    output reg           converter_strobe_out_o,
    output reg  [CW-1:0] captured_value_o,
    output reg           timer_interrupt_o,
    output reg           instruction_clock_o,
    output wire          pll_enable_o,
    output wire          instruction_clock_source_select_o
);

    // ****************************************
    // configuration state
    // ****************************************
    reg          pll_enable_q;
    reg [1:0]    div_sw_q;
    reg [1:0]    div_act_q;
    reg          tsrc_q;
    reg          isrc_q;
    reg [2:0]    ps_sw_q;
    reg [2:0]    ps_act_q;
    reg          pll_enable_d;
    reg [1:0]    div_act_d;
    reg          tsrc_d;
    reg          isrc_d;
    reg [2:0]    ps_act_d;

    // ****************************************
    // timer state
    // ****************************************
    localparam ST_IDLE    = 3'b001;
    localparam ST_PWM     = 3'b010;
    localparam ST_CAPTURE = 3'b100;

    reg [2:0]    state_q;
    reg [2:0]    state_d;
    reg [CW-1:0] count_q;
    reg [CW-1:0] count_d;
    reg          pin_prev_q;
    reg          osc_half_q;
    reg [2:0]    pll_cnt_q;

    wire         running;
    wire         cfg_write;
    wire         restart;
    wire         fast_tick;
    wire         pll_div8_tick;
    wire         timer_tick;
    wire         count_tick;
    wire         wrap_point;
    wire         overflow;
    wire         pin_edge;
    wire         capture_event;
    wire [2:0]   fast_mask;

    // divide field code to a mask of low pll counter bits
    function [2:0] div_mask;
        input [1:0] code;
        begin
            case (code)
                2'b00:   div_mask = 3'h0;
                2'b01:   div_mask = 3'h1;
                2'b10:   div_mask = 3'h3;
                default: div_mask = 3'h7;
            endcase
        end
    endfunction

    // ****************************************
    // config byte fields
    // ****************************************
    // both fields are picked from a write and kept as a stored copy
    function [1:0] div_field;
        input [7:0] cfg;
        begin
            div_field = cfg[`CFG_DIV_HI_BIT:`CFG_DIV_LO_BIT];
        end
    endfunction

    function [2:0] ps_field;
        input [7:0] cfg;
        begin
            ps_field = cfg[`CFG_PS_HI_BIT:`CFG_PS_LO_BIT];
        end
    endfunction

    assign running   = (state_q != ST_IDLE);
    assign cfg_write = write_i && (addr_i == `CFG_ADDR);

    // ****************************************
    // mode sequencing
    // ****************************************
    always @* begin
        state_d = ST_IDLE;
        case (state_q)
            ST_IDLE: begin
                if (pwm_mode_i) begin
                    state_d = ST_PWM;
                end else if (capture_mode_i) begin
                    state_d = ST_CAPTURE;
                end
            end
            ST_PWM: begin
                if (pwm_mode_i) begin
                    state_d = ST_PWM;
                end else if (capture_mode_i) begin
                    state_d = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                if (capture_mode_i && !pwm_mode_i) begin
                    state_d = ST_CAPTURE;
                end else if (pwm_mode_i) begin
                    state_d = ST_PWM;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // R02 any change of mode restarts the count
    assign restart = (state_d != state_q);

    // ****************************************
    // clock sources
    // ****************************************
    // pll pulses only count while the pll runs; software owns the lock wait
    // R12 no lock tracking here
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_cnt_q  <= 3'h0;
            osc_half_q <= 1'b0;
        end else begin
            if (!pll_enable_q) begin
                pll_cnt_q <= 3'h0;
            end else if (pll_tick_i) begin
                pll_cnt_q <= pll_cnt_q + 3'h1;
            end
            if (osc_tick_i) begin
                osc_half_q <= ~osc_half_q;
            end
        end
    end

    // R13 pll divide by 1, 2, 4 or 8
    assign fast_mask     = div_mask(div_act_q);
    assign fast_tick     = pll_enable_q && pll_tick_i && ((pll_cnt_q & fast_mask) == 3'h0);
    assign pll_div8_tick = pll_enable_q && pll_tick_i && (pll_cnt_q == 3'h0);

    // R18 instruction clock from osc/2 or pll/8
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            instruction_clock_o <= 1'b0;
        end else if (isrc_q) begin
            // a source switch could set two pulses back to back; the guard
            // keeps every pulse one cycle long at no cost to the steady rate
            instruction_clock_o <= pll_div8_tick && !instruction_clock_o;
        end else begin
            instruction_clock_o <= osc_tick_i && osc_half_q && !instruction_clock_o;
        end
    end

    // R16 timer clock source select
    assign timer_tick = tsrc_q ? fast_tick : instruction_clock_o;

    // R03 prescaled timer clock drives the count
    // R21 ratio 1 to 8
    prescale_divider #(
        .WIDTH     (3)
    ) u_prescale (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .restart_i (restart || !running),
        .tick_i    (timer_tick),
        .ratio_i   (ps_act_q),
        .tick_o    (count_tick)
    );

    // ****************************************
    // counter
    // ****************************************
    // R05 pwm wraps at period, capture at full scale
    assign wrap_point = (state_q == ST_PWM) ? (count_q == period_i) : (count_q == `COUNT_MAX);
    assign overflow   = running && !restart && count_tick && wrap_point;

    always @* begin
        count_d = count_q;
        if (restart || !running) begin
            count_d = `COUNT_RESET;
        // R04 reload zero and keep counting
        end else if (overflow) begin
            count_d = `COUNT_RESET;
        end else if (count_tick) begin
            count_d = count_q + 12'h001;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            count_q <= `COUNT_RESET;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // ****************************************
    // capture and outputs
    // ****************************************
    assign pin_edge = capture_rising_i ?
                      (half_bridge_out_b_or_capture_in_i && !pin_prev_q) :
                      (!half_bridge_out_b_or_capture_in_i && pin_prev_q);
    assign capture_event = (state_q == ST_CAPTURE) && !restart && pin_edge;

    // pin b only drives in pwm mode; in capture it is the trigger input
    assign half_bridge_out_b_or_capture_in_oe_o = (state_q == ST_PWM);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_prev_q                        <= 1'b0;
            captured_value_o                  <= `COUNT_RESET;
            timer_interrupt_o                 <= 1'b0;
            half_bridge_out_a_o               <= 1'b0;
            half_bridge_out_b_or_capture_in_o <= 1'b0;
            converter_strobe_out_o            <= 1'b0;
        end else begin
            pin_prev_q <= half_bridge_out_b_or_capture_in_i;
            // R07 store count on selected edge
            if (capture_event) begin
                captured_value_o <= count_q;
            end
            // R06 request on overflow and capture
            timer_interrupt_o <= (overflow && overflow_irq_en_i) ||
                                 (capture_event && capture_irq_en_i);
            // R08 out a and strobe in both modes
            half_bridge_out_a_o    <= running && (count_q >= compare_a_i);
            converter_strobe_out_o <= running && (count_q >= compare_b_i);
            half_bridge_out_b_or_capture_in_o <= (state_q == ST_PWM) && (count_q >= compare_a_i);
        end
    end

    // ****************************************
    // configuration register
    // ****************************************
    always @* begin
        pll_enable_d = pll_enable_q;
        tsrc_d       = tsrc_q;
        isrc_d       = isrc_q;
        div_act_d    = div_act_q;
        ps_act_d     = ps_act_q;
        if (cfg_write) begin
            // R11 pll enable frozen while running
            if (!running) begin
                pll_enable_d = wdata_i[`CFG_PLL_EN_BIT];
            end
            // R10 R17 source select frozen while running, set only with pll on
            if (!running && (pll_enable_d || !wdata_i[`CFG_TSRC_BIT])) begin
                tsrc_d = wdata_i[`CFG_TSRC_BIT];
            end
            // R19 R20 instruction select free, zero without pll
            isrc_d = pll_enable_d && wdata_i[`CFG_ISRC_BIT];
        end
        // R14 R22 stored fields take effect when idle or at overflow
        if (!running || overflow) begin
            div_act_d = cfg_write ? div_field(wdata_i) : div_sw_q;
            ps_act_d  = cfg_write ? ps_field(wdata_i) : ps_sw_q;
        end
    end

    // R09 config resets to all zero
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_enable_q <= 1'b0;
            div_sw_q     <= 2'h0;
            div_act_q    <= 2'h0;
            tsrc_q       <= 1'b0;
            isrc_q       <= 1'b0;
            ps_sw_q      <= 3'h0;
            ps_act_q     <= 3'h0;
        end else begin
            pll_enable_q <= pll_enable_d;
            tsrc_q       <= tsrc_d;
            isrc_q       <= isrc_d;
            div_act_q    <= div_act_d;
            ps_act_q     <= ps_act_d;
            // stored copies always take the write, even while running
            if (cfg_write) begin
                div_sw_q <= div_field(wdata_i);
                ps_sw_q  <= ps_field(wdata_i);
            end
        end
    end

    assign pll_enable_o                      = pll_enable_q;
    assign instruction_clock_source_select_o = isrc_q;

    // ****************************************
    // register read port
    // ****************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (read_i) begin
            case (addr_i)
                // R15 R22 fields read back as written
                `CFG_ADDR:        rdata_o <= {pll_enable_q, div_sw_q, tsrc_q, isrc_q, ps_sw_q};
                // R01 read-only count halves
                `COUNT_LOW_ADDR:  rdata_o <= count_q[7:0];
                `COUNT_HIGH_ADDR: rdata_o <= {4'h0, count_q[11:8]};
                default:          rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule // pwm_timer_clock_prescale

// ==== logic/pwm_timer_map.vh ====
// register map, field positions and reset values of the pwm timer clock block
// assumes a byte-wide register port and a single 10 MHz system clock
// How it works
// R01 - read-only 12-bit count via high/low registers
// R02 - count clears on reset and mode entry
// R03 - count advances on prescaled timer clock
// R04 - overflow reloads zero, counting continues
// R05 - pwm wraps at period, capture at 0xFFF
// R06 - interrupt request on overflow and capture
// R07 - capture stores count on selected pin edge
// R08 - out a and strobe run in capture
// R09 - config register resets to 0x00
// R10 - timer clock source frozen while running
// R11 - pll enable writes ignored while running
// R12 - software waits pll lock before use
// R13 - pll divide field selects 1/2/4/8
// R14 - divide change applied at next overflow
// R15 - divide field reads last written value
// R16 - source select picks instruction or pll clock
// R17 - source select blocked without pll or running
// R18 - instruction clock from osc/2 or pll/8
// R19 - instruction select forced zero without pll
// R20 - instruction select changeable any time
// R21 - prescale field divides by 1 to 8
// R22 - prescale change applied at overflow
// R23 - prescale value n divides by n+1
// R24 - prescale divider restarts with counter
`ifndef PWM_TIMER_MAP_VH
`define PWM_TIMER_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define CFG_ADDR        8'hA4
`define COUNT_LOW_ADDR  8'hB0
`define COUNT_HIGH_ADDR 8'hB1

// ****************************************
// config field positions
// ****************************************
`define CFG_PLL_EN_BIT  7
`define CFG_DIV_HI_BIT  6
`define CFG_DIV_LO_BIT  5
`define CFG_TSRC_BIT    4
`define CFG_ISRC_BIT    3
`define CFG_PS_HI_BIT   2
`define CFG_PS_LO_BIT   0

// ****************************************
// reset and limit values
// ****************************************
`define CFG_RESET       8'h00
`define COUNT_RESET     12'h000
`define COUNT_MAX       12'hFFF

`endif

// ==== logic/prescale_divider.v ====
// divides a timer clock enable by a programmable ratio of 1 to 8
// assumes tick_i is a one-cycle enable and ratio_i is stable between overflows
`timescale 1ns/1ns
module prescale_divider #(
    parameter WIDTH = 3
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             restart_i,
    input  wire             tick_i,
    input  wire [WIDTH-1:0] ratio_i,
    output wire             tick_o
);
    reg [WIDTH-1:0] count_q;
    reg [WIDTH-1:0] count_d;

    // R23 ratio n divides by n+1
    assign tick_o = tick_i && (count_q == ratio_i) && !restart_i;

    always @* begin
        count_d = count_q;
        // R24 restart with the counter
        if (restart_i) begin
            count_d = {WIDTH{1'b0}};
        end else if (tick_i) begin
            if (count_q == ratio_i) begin
                count_d = {WIDTH{1'b0}};
            end else begin
                count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end
endmodule // prescale_divider

// ==== tb/pwm_timer_chk.sv ====
// checker for the pwm timer clock block, sees only its ports
// assumes the bind below attaches it to every instance of the block
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module pwm_timer_chk #(
    parameter CW = 12
) (
    input wire       clk_i,
    input wire       rst_n_i,
    input wire [7:0] addr_i,
    input wire       read_i,
    input wire [7:0] rdata_o,
    input wire       pwm_mode_i,
    input wire       capture_mode_i,
    input wire       half_bridge_out_b_or_capture_in_oe_o,
    input wire       half_bridge_out_a_o,
    input wire       converter_strobe_out_o,
    input wire       instruction_clock_o,
    input wire       pll_enable_o,
    input wire       instruction_clock_source_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire run = pwm_mode_i | capture_mode_i;
    // three cycles of history so the state register has caught up with the mode
    sequence run3; run && $past(run) && $past(run, 2); endsequence
    sequence idle3; !run && !$past(run) && !$past(run, 2); endsequence
    chk_rdata_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    chk_unmapped_read: assert property (read_i && addr_i != `CFG_ADDR
        && addr_i != `COUNT_LOW_ADDR && addr_i != `COUNT_HIGH_ADDR |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_count_high_width: assert property (read_i && addr_i == `COUNT_HIGH_ADDR
        |=> rdata_o[7:4] == 4'h0) else $error("count high wider than 4 bits");
    chk_cfg_readback: assert property (read_i && addr_i == `CFG_ADDR
        |=> rdata_o[7] == $past(pll_enable_o)
        && rdata_o[3] == $past(instruction_clock_source_select_o))
        else $error("config readback differs from bits");
    chk_isrc_needs_pll: assert property (instruction_clock_source_select_o
        |-> pll_enable_o) else $error("fast instruction clock without pll");
    chk_pll_frozen_run: assert property (run3 |-> $stable(pll_enable_o))
        else $error("pll enable changed while running");
    chk_oe_in_pwm: assert property ($past(pwm_mode_i) == pwm_mode_i
        |-> half_bridge_out_b_or_capture_in_oe_o == pwm_mode_i)
        else $error("pin enable does not follow pwm mode");
    chk_outputs_idle: assert property (idle3
        |-> !half_bridge_out_a_o && !converter_strobe_out_o)
        else $error("outputs active while stopped");
    chk_iclk_pulse: assert property (instruction_clock_o |=> !instruction_clock_o)
        else $error("instruction clock pulse too long");
endmodule // pwm_timer_chk

bind pwm_timer_clock_prescale pwm_timer_chk #(.CW(CW)) chk_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .read_i(read_i),
    .rdata_o(rdata_o), .pwm_mode_i(pwm_mode_i), .capture_mode_i(capture_mode_i),
    .half_bridge_out_b_or_capture_in_oe_o(half_bridge_out_b_or_capture_in_oe_o),
    .half_bridge_out_a_o(half_bridge_out_a_o), .converter_strobe_out_o(converter_strobe_out_o),
    .instruction_clock_o(instruction_clock_o), .pll_enable_o(pll_enable_o),
    .instruction_clock_source_select_o(instruction_clock_source_select_o));

// ==== tb/cap_pin_model.sv ====
// far side of the shared half-bridge pin: a capture source
// assumes the block drives the line only while its enable is high
`timescale 1ns/1ns
module cap_pin_model (
    input  wire level_i,
    input  wire oe_i,
    input  wire drv_i,
    output wire pin_o
);
    // the block owns the line in pwm mode, the source drives it otherwise
    assign pin_o = oe_i ? drv_i : level_i;
endmodule // cap_pin_model

// ==== tb/tb_pwm_timer_clock_prescale.sv ====
// self-checking bench for the pwm timer clock block
// assumes oscillator and pll rate enables are high on every cycle
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module tb_pwm_timer_clock_prescale;
    reg         clk_i, rst_n_i, write_i, read_i, sel, lvl;
    reg         pwm_mode_i, capture_mode_i, rising, ov_en, cap_en;
    reg  [7:0]  addr_i, wdata_i, lo;
    reg  [15:0] d;
    reg  [11:0] period_i, cmp_a, cmp_b;
    wire [7:0]  rdata_o;
    wire [11:0] cap_v;
    wire        pin, pin_o, pin_oe, out_a, strobe, irq, iclk, pll_en, isrc;
    wire        ev = sel ? iclk : irq;
    integer     failures, num_checks, i, n, per;

    pwm_timer_clock_prescale pwm_timer_clock_prescale_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
        .rdata_o(rdata_o), .osc_tick_i(1'b1), .pll_tick_i(1'b1), .pwm_mode_i(pwm_mode_i),
        .capture_mode_i(capture_mode_i), .capture_rising_i(rising),
        .overflow_irq_en_i(ov_en), .capture_irq_en_i(cap_en), .period_i(period_i),
        .compare_a_i(cmp_a), .compare_b_i(cmp_b), .half_bridge_out_b_or_capture_in_i(pin),
        .half_bridge_out_b_or_capture_in_o(pin_o),
        .half_bridge_out_b_or_capture_in_oe_o(pin_oe), .half_bridge_out_a_o(out_a),
        .converter_strobe_out_o(strobe), .captured_value_o(cap_v),
        .timer_interrupt_o(irq), .instruction_clock_o(iclk), .pll_enable_o(pll_en),
        .instruction_clock_source_select_o(isrc));
    cap_pin_model cap_pin_model_i (.level_i(lvl), .oe_i(pin_oe), .drv_i(pin_o), .pin_o(pin));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ****
    // tasks
    // ****
    task cmp(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clk_i);
            addr_i <= a;
            wdata_i <= v;
            write_i <= 1'b1;
            @(posedge clk_i);
            write_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk_i);
            addr_i <= a;
            read_i <= 1'b1;
            @(posedge clk_i);
            read_i <= 1'b0;
            #1 d = {8'h00, rdata_o};
        end
    endtask
    // cycles until the next event; gives up after 9000 so a dead timer shows
    task wait_ev(output integer g);
        begin
            g = 0;
            do begin
                @(posedge clk_i);
                #1 g = g + 1;
            end while (!ev && g < 9000);
        end
    endtask
    task gap(input s, output integer g);
        begin
            sel = s;
            wait_ev(g);
            wait_ev(g);
        end
    endtask
    // overflow spacing: source rate times prescale times period length
    function [15:0] exp_gap(input integer s, input integer v, input integer p, input integer r);
        exp_gap = (s ? (1 << v) : 2) * (p + 1) * (r + 1);
    endfunction
    task end_of_test;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    initial begin
        #(60000 * 100);
        failures = failures + 1;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test;
    end

    // ****
    // main sequence
    // ****
    initial begin
        {rst_n_i, write_i, read_i, sel, lvl, pwm_mode_i, capture_mode_i} = 7'h00;
        {rising, ov_en, cap_en, addr_i, wdata_i} = 19'h00000;
        {period_i, cmp_a, cmp_b} = 36'hFFFFFFFFF;
        failures = 0;
        num_checks = 0;
        n = $urandom(93866);
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`CFG_ADDR);
        cmp(d, 16'h0000);
        rd(`COUNT_LOW_ADDR);
        cmp(d, 16'h0000);
        rd(`COUNT_HIGH_ADDR);
        cmp(d, 16'h0000);
        rd(8'h55);
        cmp(d, 16'h0000);
        wr(`CFG_ADDR, 8'h18);
        rd(`CFG_ADDR);
        cmp(d, 16'h0000);
        // pll enabled long before any pll clock is picked
        wr(`CFG_ADDR, 8'h80);
        rd(`CFG_ADDR);
        cmp(d, 16'h0080);
        $display("test register reset done");
        ov_en <= 1'b1;
        // every prescale code, every divide code, both timer sources
        for (i = 0; i < 8; i = i + 1) begin
            per = 1 + $urandom % 6;
            period_i <= per[11:0];
            cmp_a <= $urandom % per;
            cmp_b <= $urandom % 4096;
            wr(`CFG_ADDR, {1'b1, i[2:1], i[0], 1'b0, i[2:0]});
            rd(`CFG_ADDR);
            cmp(d, {9'h001, i[2:1], i[0], 1'b0, i[2:0]});
            pwm_mode_i <= 1'b1;
            gap(1'b0, n);
            cmp(n[15:0], exp_gap(i % 2, i / 2, i, per));
            pwm_mode_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        $display("test rate table done");
        period_i <= 12'h003;
        cmp_a <= 12'h000;
        wr(`CFG_ADDR, 8'h90);
        pwm_mode_i <= 1'b1;
        gap(1'b0, n);
        // divide change waits for the overflow, then the new rate holds
        wr(`CFG_ADDR, 8'hB0);
        wait_ev(n);
        cmp(n[15:0], exp_gap(1, 0, 0, 3) - 16'h0002);
        wait_ev(n);
        wait_ev(n);
        cmp(n[15:0], exp_gap(1, 1, 0, 3));
        cmp({14'h0000, pin_oe, pin_o}, 16'h0003);
        pwm_mode_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        wr(`CFG_ADDR, 8'h81);
        pwm_mode_i <= 1'b1;
        gap(1'b0, n);
        // clearing bit 7 and setting bit 4 are refused, prescale waits for overflow
        wr(`CFG_ADDR, 8'h13);
        wait_ev(n);
        cmp(n[15:0], exp_gap(0, 0, 1, 3) - 16'h0002);
        wait_ev(n);
        cmp(n[15:0], exp_gap(0, 0, 3, 3));
        rd(`CFG_ADDR);
        cmp(d, 16'h0083);
        wr(`CFG_ADDR, 8'h0B);
        gap(1'b1, n);
        cmp(n[15:0], 16'h0008);
        pwm_mode_i <= 1'b0;
        $display("test run mode writes done");
        wr(`CFG_ADDR, 8'h80);
        capture_mode_i <= 1'b1;
        gap(1'b0, n);
        cmp(n[15:0], exp_gap(0, 0, 0, 4095));
        capture_mode_i <= 1'b0;
        ov_en <= 1'b0;
        wr(`CFG_ADDR, 8'h87);
        cmp_a <= 12'h000;
        cmp_b <= 12'h000;
        cap_en <= 1'b1;
        rising <= 1'b1;
        capture_mode_i <= 1'b1;
        rd(`COUNT_LOW_ADDR);
        cmp(d, 16'h0000);
        repeat ($urandom % 200 + 20) @(posedge clk_i);
        rd(`COUNT_LOW_ADDR);
        lo = d[7:0];
        rd(`COUNT_HIGH_ADDR);
        lvl <= 1'b1;
        wait_ev(n);
        cmp({15'h0000, n < 5}, 16'h0001);
        // one tick may land between the count read and the edge
        cmp({15'h0000, cap_v - {d[3:0], lo} <= 12'h001}, 16'h0001);
        cmp({15'h0000, out_a}, 16'h0001);
        cmp({15'h0000, strobe}, 16'h0001);
        cmp({14'h0000, pin_oe, pin_o}, 16'h0000);
        rising <= 1'b0;
        repeat (4) @(posedge clk_i);
        lvl <= 1'b0;
        wait_ev(n);
        cmp({15'h0000, n < 5}, 16'h0001);
        lvl <= 1'b1;
        wait_ev(n);
        cmp(n[15:0], 16'h2328);
        capture_mode_i <= 1'b0;
        $display("test capture done");
        end_of_test;
    end
endmodule // tb_pwm_timer_clock_prescale
